// File: design/can_acceptance_filter_config.sv
/*
 * Register side of the CAN acceptance-filter configuration: filter control
 * word, message buffer base address and the operating-mode field.
 * Assumes one-cycle read/write strobes, never together; read data the next cycle.
 */
// Notes on behaviour
// R01 - Each filter has a one-bit enable
// R02 - Two-bit mask choice selects mask 0 to 3
// R03 - Five-bit field selects destination FIFO 0-31
// R04 - Filter n uses byte n: on, mask, fifo
// R05 - Mask and FIFO fields locked while enabled
// R06 - Base address gives start of all buffers
// R07 - Base bits 1:0 read-only zero
// R08 - Base writable only in configuration mode 100
// R09 - All writable fields reset to zero, except the mode field, which resets to configuration mode 100
`timescale 1ns/100ps
module can_acceptance_filter_config
    import can_filt_pkg::*;
(
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    // Register port
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    // Filter configuration towards the matching engine
    output logic      [3:0]  o_filter_on,
    output logic      [7:0]  o_filter_mask_choice,
    output logic      [19:0] o_filter_fifo_target,
    output logic      [31:0] o_buffer_base,
    output logic      [2:0]  o_operating_mode
);
    import can_filt_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        // Read data of the last read, zero when no read was made
        logic [31:0] rdata;
        // Held configuration
        logic [31:0] base;
        logic [2:0]  opmode;
        // Registered copies of the filter word towards the matching engine
        logic [3:0]  on;
        logic [7:0]  mask;
        logic [19:0] fifo;
    } top_state_t;

    top_state_t  state_ff;
    top_state_t  nxt_state;
    logic [31:0] filter_word;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
        hit = (a == ref_a);
    endfunction

    // One-hot register select; a miss lands on the empty code, so unmapped
    // reads return zero and unmapped writes change nothing
    typedef enum logic [3:0] {
        SEL_NONE   = 4'b0001,
        SEL_FILTER = 4'b0010,
        SEL_BASE   = 4'b0100,
        SEL_CTRL   = 4'b1000
    } reg_sel_t;

    function automatic reg_sel_t decode_sel(input logic [7:0] a);
        reg_sel_t sel;
        sel = SEL_NONE;
        if (hit(a, ADDR_FILTER_CTRL)) begin
            sel = SEL_FILTER;
        end else if (hit(a, ADDR_BUFFER_BASE)) begin
            sel = SEL_BASE;
        end else if (hit(a, ADDR_CTRL_WORD)) begin
            sel = SEL_CTRL;
        end
        decode_sel = sel;
    endfunction

    // Word alignment is forced on the write and again on the read path
    function automatic logic [31:0] align_word(input logic [31:0] w);
        align_word = w & BASE_WRITE_MASK;
    endfunction

    // Only the mode field of the controller control word is held here;
    // every other bit of it reads zero
    function automatic logic [31:0] ctrl_image(input logic [2:0] mode);
        logic [31:0] img;
        img                  = '0;
        img[OPMODE_LSB +: 3] = mode;
        ctrl_image           = img;
    endfunction

    // Split the filter word into per-filter groups, filter n from byte n
    function automatic logic [3:0] gather_on(input logic [31:0] w);
        logic [3:0] v;
        v = '0;
        for (int n = 0; n < NUM_FILTERS; n++) begin
            v[n] = w[8*n + FILT_ON_BIT];
        end
        gather_on = v;
    endfunction

    function automatic logic [7:0] gather_mask(input logic [31:0] w);
        logic [7:0] v;
        v = '0;
        for (int n = 0; n < NUM_FILTERS; n++) begin
            v[2*n +: 2] = w[8*n + MASK_LSB +: 2];
        end
        gather_mask = v;
    endfunction

    function automatic logic [19:0] gather_fifo(input logic [31:0] w);
        logic [19:0] v;
        v = '0;
        for (int n = 0; n < NUM_FILTERS; n++) begin
            v[5*n +: 5] = w[8*n + FIFO_LSB +: 5];
        end
        gather_fifo = v;
    endfunction

    // ------------------------------------------------------------
    // Access qualification
    // ------------------------------------------------------------
    reg_sel_t    wr_sel;
    reg_sel_t    rd_sel;
    logic        filter_wr;
    logic        ctrl_wr;
    logic        base_wr_ok;

    assign wr_sel     = i_wr ? decode_sel(i_addr) : SEL_NONE;
    assign rd_sel     = i_rd ? decode_sel(i_addr) : SEL_NONE;
    assign filter_wr  = (wr_sel == SEL_FILTER);
    assign ctrl_wr    = (wr_sel == SEL_CTRL);
    // Gate on the mode already held, so a mode change and base write cannot race
    assign base_wr_ok = (wr_sel == SEL_BASE) && (state_ff.opmode == OPMODE_CONFIG); // R08

    // ------------------------------------------------------------
    // Filter bytes
    // ------------------------------------------------------------
    // Each slot owns its lock: the stored enable of that byte decides
    genvar g;
    generate
        for (g = 0; g < NUM_FILTERS; g++) begin : g_slot
            filter_byte_slot u_slot (
                .i_mclk  (i_mclk),
                .i_rst_n (i_rst_n),
                .i_wr    (filter_wr),
                .i_wdata (i_wdata[8*g +: 8]),                          // R04
                .o_byte  (filter_word[8*g +: 8])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_state.rdata = '0;
        // The engine sees the filter word one edge late; the lock decision
        // always uses the slot's own stored enable, never this copy
        nxt_state.on   = gather_on(filter_word);                                  // R01
        nxt_state.mask = gather_mask(filter_word);                                // R02
        nxt_state.fifo = gather_fifo(filter_word);                                // R03
        // Mode field of the controller control word
        if (ctrl_wr) begin
            nxt_state.opmode = i_wdata[OPMODE_LSB +: 3];
        end

        // Buffer base: only in configuration mode, low bits forced to zero
        if (base_wr_ok) begin                                                     // R08
            nxt_state.base = align_word(i_wdata);                                 // R06 R07
        end

        // Read data stands one cycle after the strobe and is zero otherwise
        case (rd_sel)
            SEL_FILTER: begin
                nxt_state.rdata = filter_word;                                    // R04
            end
            SEL_BASE: begin
                nxt_state.rdata = align_word(state_ff.base);                      // R07
            end
            SEL_CTRL: begin
                nxt_state.rdata = ctrl_image(state_ff.opmode);
            end
            SEL_NONE: begin
                nxt_state.rdata = '0;
            end
            default: begin
                nxt_state.rdata = '0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Mode resets to configuration so the base can be set up right after reset
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_ff        <= '0;                                                // R09
            state_ff.opmode <= OPMODE_RST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Every output is a flop of the state word; nothing combinational reaches a pin
    assign o_rdata              = state_ff.rdata;
    assign o_filter_on          = state_ff.on;
    assign o_filter_mask_choice = state_ff.mask;
    assign o_filter_fifo_target = state_ff.fifo;
    assign o_buffer_base        = state_ff.base;
    assign o_operating_mode     = state_ff.opmode;
endmodule

// File: design/filter_byte_slot.sv
/*
 * One filter's control byte: enable, mask choice, FIFO target.
 * Assumes the parent supplies a qualified write strobe for this byte.
 */
`timescale 1ns/100ps
module filter_byte_slot
    import can_filt_pkg::*;
(
    // Clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_rst_n,
    // Write side
    input  wire logic       i_wr,
    input  wire logic [7:0] i_wdata,
    // Stored byte
    output logic      [7:0] o_byte
);
    typedef struct packed {
        logic [7:0] byte_val;
    } slot_state_t;

    slot_state_t state_ff;
    slot_state_t nxt_state;

    always_comb begin
        nxt_state = state_ff;
        if (i_wr) begin
            nxt_state.byte_val[FILT_ON_BIT] = i_wdata[FILT_ON_BIT];    // R01
            // Locked while enabled: only the enable bit may change
            if (!state_ff.byte_val[FILT_ON_BIT]) begin                 // R05
                nxt_state.byte_val[6:0] = i_wdata[6:0];                // R02 R03 R04
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_ff <= '0;                                            // R09
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign o_byte = state_ff.byte_val;
endmodule

// File: inc/can_filt_pkg.sv
/*
 * Constants for the acceptance-filter and buffer-base configuration block.
 * Assumes a plain register port with one-cycle strobes and a 32-bit data path.
 */
package can_filt_pkg;

    // ------------------------------------------------------------
    // Register map (indices chosen locally, byte address = 4 * index)
    // ------------------------------------------------------------
    localparam logic [7:0]  ADDR_FILTER_CTRL  = 8'h00;
    localparam logic [7:0]  ADDR_BUFFER_BASE  = 8'h04;
    localparam logic [7:0]  ADDR_CTRL_WORD    = 8'h08;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int          NUM_FILTERS       = 4;
    localparam int          FILT_ON_BIT       = 7;
    localparam int          MASK_LSB          = 5;
    localparam int          FIFO_LSB          = 0;
    localparam int          OPMODE_LSB        = 21;
    localparam logic [2:0]  OPMODE_CONFIG     = 3'h4;
    localparam logic [31:0] BASE_WRITE_MASK   = 32'hFFFF_FFFC;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] FILTER_CTRL_RST   = 32'h0000_0000;
    localparam logic [31:0] BUFFER_BASE_RST   = 32'h0000_0000;
    localparam logic [2:0]  OPMODE_RST        = 3'h4;

endpackage

// File: test/can_acceptance_filter_config_tb.sv
/* Bench for the filter config block. Assumes the register map of the package. */
`timescale 1ns/100ps
module can_acceptance_filter_config_tb;
    import can_filt_pkg::*;
    logic        i_mclk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0;
    logic [7:0]  i_addr = 0, o_filter_mask_choice;
    logic [31:0] i_wdata = 0, o_rdata, o_buffer_base, slot_addr, d;
    logic [3:0]  o_filter_on;
    logic [19:0] o_filter_fifo_target;
    logic [2:0]  o_operating_mode;
    int          fails = 0, num_checks = 0, cyc = 0;
    can_acceptance_filter_config i_can_acceptance_filter_config (.i_mclk, .i_rst_n, .i_addr, .i_wdata,
        .i_wr, .i_rd, .o_rdata, .o_filter_on, .o_filter_mask_choice, .o_filter_fifo_target,
        .o_buffer_base, .o_operating_mode);
    msg_ram_model i_msg_ram_model (.i_base(o_buffer_base), .i_slot(8'h02), .o_addr(slot_addr));
    initial forever #2.5 i_mclk = ~i_mclk;
    // Whole run needs under a hundred cycles
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            fails++;
            end_of_test;
        end
    end
    task chk(input logic [31:0] s, e, input string n);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("unexpected %s exp %h got %h", n, e, s);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_mclk) {i_wr, i_addr, i_wdata} <= {1'b1, a, v};
        @(posedge i_mclk) i_wr <= 0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input string n);
        @(posedge i_mclk) {i_rd, i_addr} <= {1'b1, a};
        @(posedge i_mclk) i_rd <= 0;
        #1 chk(o_rdata, e, n);
    endtask
    task t_filter;
        rd(8'h00, 32'h0, "filter reset");
        wr(8'h00, 32'h7F4A_3500);
        rd(8'h00, 32'h7F4A_3500, "fields");
        chk(o_filter_fifo_target, {5'd31, 5'd10, 5'd21, 5'd0}, "fifo out");
        wr(8'h00, 32'hFFCA_B580);
        rd(8'h00, 32'hFFCA_B580, "enable");
        chk(o_filter_on, 4'hF, "on out");
        chk(o_filter_mask_choice, {2'd3, 2'd2, 2'd1, 2'd0}, "mask out");
        wr(8'h00, 32'h8000_0000);
        rd(8'h00, 32'hFF4A_3500, "locked");
        wr(8'h00, 32'h0);
        rd(8'h00, 32'h7F00_0000, "unlock");
        $display("filter test done");
    endtask
    task t_base;
        rd(8'h04, 32'h0, "base reset");
        rd(8'h08, 32'h0080_0000, "mode reset");
        chk(o_operating_mode, 3'h4, "mode out");
        wr(8'h04, 32'h1234_5677);
        rd(8'h04, 32'h1234_5674, "base");
        chk(slot_addr, 32'h1234_5694, "slot");
        wr(8'h08, 32'h0);
        rd(8'h08, 32'h0, "mode off");
        chk(o_operating_mode, 3'h0, "mode out off");
        wr(8'h04, 32'hFFFF_FFFF);
        rd(8'h04, 32'h1234_5674, "base lock");
        rd(8'h10, 32'h0, "unmapped");
        wr(8'h08, 32'h0080_0000);
        wr(8'h04, 32'hFFFF_FFFF);
        rd(8'h04, 32'hFFFF_FFFC, "base cfg");
        $display("base test done");
    endtask
    task t_reset;
        @(posedge i_mclk) i_rst_n <= 0;
        repeat (2) @(posedge i_mclk);
        i_rst_n <= 1;
        #1 chk(o_buffer_base, 32'h0, "base after reset");
        chk(o_filter_fifo_target, 20'h0, "fifo after reset");
        chk(o_filter_mask_choice, 8'h0, "mask after reset");
        chk(o_filter_on, 4'h0, "on after reset");
        chk(o_operating_mode, 3'h4, "mode after reset");
        rd(8'h00, 32'h0, "filter after reset");
        $display("reset test done");
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge i_mclk);
        i_rst_n <= 1;
        t_filter;
        t_base;
        t_reset;
        end_of_test;
    end
endmodule

// File: test/can_filt_chk.sv
/* Port checker for the filter config block. Assumes binding to its top. */
`timescale 1ns/100ps
module can_filt_chk (
    input wire logic        i_mclk, i_rst_n, i_wr, i_rd,
    input wire logic [7:0]  i_addr, o_filter_mask_choice,
    input wire logic [31:0] i_wdata, o_rdata, o_buffer_base,
    input wire logic [3:0]  o_filter_on,
    input wire logic [19:0] o_filter_fifo_target,
    input wire logic [2:0]  o_operating_mode
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    sequence base_wr; i_wr && i_addr == 8'h04; endsequence
    sequence filt_wr; i_wr && i_addr == 8'h00; endsequence
    base_align_a: assert property (o_buffer_base[1:0] == 2'h0) else $error("base unaligned");
    base_write_a: assert property (base_wr ##0 o_operating_mode == 3'h4 |=>
        o_buffer_base == ($past(i_wdata) & 32'hFFFF_FFFC)) else $error("base write lost");
    base_lock_a: assert property (base_wr ##0 o_operating_mode != 3'h4 |=>
        $stable(o_buffer_base)) else $error("base changed");
    mask_lock_a: assert property (o_filter_on[0] |=> $stable(o_filter_mask_choice[1:0])
        && $stable(o_filter_fifo_target[4:0])) else $error("locked field moved");
    field_write_a: assert property (filt_wr ##1 !o_filter_on[3] |=>
        o_filter_mask_choice[7:6] == $past(i_wdata[30:29], 2)
        && o_filter_fifo_target[19:15] == $past(i_wdata[28:24], 2)) else $error("field write lost");
    on_write_a: assert property (filt_wr |-> ##2 o_filter_on ==
        $past({i_wdata[31], i_wdata[23], i_wdata[15], i_wdata[7]}, 2)) else $error("enable wrong");
    rd_filt_a: assert property (i_rd && i_addr == 8'h00 |=> o_rdata[7:0] ==
        {o_filter_on[0], o_filter_mask_choice[1:0], o_filter_fifo_target[4:0]}) else $error("filter read");
    rd_base_a: assert property (i_rd && i_addr == 8'h04 |=>
        o_rdata == $past(o_buffer_base)) else $error("base read");
    ctrl_write_a: assert property (i_wr && i_addr == 8'h08 |=>
        o_operating_mode == $past(i_wdata[23:21])) else $error("mode write lost");
    rd_idle_a: assert property (!i_rd |=> o_rdata == 32'h0000_0000) else $error("read data not cleared");
endmodule
bind can_acceptance_filter_config can_filt_chk i_can_filt_chk (.i_mclk, .i_rst_n, .i_wr, .i_rd,
    .i_addr, .o_filter_mask_choice, .i_wdata, .o_rdata, .o_buffer_base, .o_filter_on,
    .o_filter_fifo_target, .o_operating_mode);

// File: test/msg_ram_model.sv
/* Message RAM side: slot address of buffer n. Assumes fixed-size buffers. */
`timescale 1ns/100ps
module msg_ram_model #(parameter int BUF_BYTES = 16) (
    input  wire logic [31:0] i_base,
    input  wire logic [7:0]  i_slot,
    output logic      [31:0] o_addr
);
    // Buffers follow each other from the base
    assign o_addr = i_base + i_slot * BUF_BYTES;
endmodule
